// [tb_timer8_single_compare.sv]
`default_nettype none
module tb_timer8_single_compare;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clock;
    logic        resetn;
    logic [4:0]  avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    logic [3:0]  avs_byteenable;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        cmp_irq_ack;
    logic        ext_clock_pin;
    logic        compare_output_pin;
    logic        ovf_irq;
    logic        cmp_irq;
    int          err_count;
    int          n_checks;
    logic [7:0]  rd;
    int          hi_cnt;

    tmr_timer8 dut (
        .clock(clock), .resetn(resetn), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .cmp_irq_ack(cmp_irq_ack),
        .ext_clock_pin(ext_clock_pin), .compare_output_pin(compare_output_pin),
        .ovf_irq(ovf_irq), .cmp_irq(cmp_irq));

    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    task automatic conclude();
        if (err_count == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    function automatic logic [7:0] ctl(logic [1:0] com, logic [1:0] wgm, logic [2:0] cs);
        return {1'b0, com, wgm, cs};
    endfunction

    // Request held until waitrequest is seen low; read data taken at that same edge
    task automatic bus(input logic rw, input logic [2:0] idx, input logic [7:0] wd);
        int n;
        @(posedge clock);
        avs_address   <= {idx, 2'b00};
        avs_read      <= ~rw;
        avs_write     <= rw;
        avs_writedata <= {24'h0, wd};
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        rd = avs_readdata[7:0];
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
        if (n >= 50) begin
            err_count++;
            $display("MISMATCH t=%0t bus timeout", $time);
            conclude();
        end
    endtask

    task automatic check_reg(input logic [2:0] idx, input logic [7:0] exp);
        bus(1'b0, idx, 8'h00);
        n_checks++;
        if (rd !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t reg %0d got %h exp %h", $time, idx, rd, exp);
        end
    endtask

    task automatic check_bit(input logic got, input logic exp);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t bit got %b exp %b", $time, got, exp);
        end
    endtask

    task automatic s_regs();
        check_reg(tmr_pkg::IDX_CTRL, tmr_pkg::CTRL_RST);
        check_reg(tmr_pkg::IDX_COUNT, tmr_pkg::COUNT_RST);
        check_reg(tmr_pkg::IDX_CMP, tmr_pkg::CMP_RST);
        bus(1'b1, tmr_pkg::IDX_COUNT, 8'ha5);
        bus(1'b1, tmr_pkg::IDX_CMP, 8'h5a);
        bus(1'b1, 3'h6, 8'hff);
        check_reg(tmr_pkg::IDX_CMP, 8'h5a);
        check_reg(3'h6, 8'h00);
        repeat (20) @(posedge clock);
        check_reg(tmr_pkg::IDX_COUNT, 8'ha5);
    endtask

    task automatic s_ovf();
        bus(1'b1, tmr_pkg::IDX_COUNT, 8'hf0);
        bus(1'b1, tmr_pkg::IDX_CTRL, ctl(tmr_pkg::COM_OFF, tmr_pkg::WGM_NORMAL, tmr_pkg::CS_DIV1));
        repeat (30) @(posedge clock);
        bus(1'b1, tmr_pkg::IDX_CTRL, 8'h00);
        check_reg(tmr_pkg::IDX_FLAG, 8'h01);
        check_bit(ovf_irq, 1'b0);
        bus(1'b1, tmr_pkg::IDX_MASK, 8'h01);
        repeat (2) @(posedge clock);
        check_bit(ovf_irq, 1'b1);
        bus(1'b1, tmr_pkg::IDX_FLAG, 8'h01);
        check_reg(tmr_pkg::IDX_FLAG, 8'h00);
        repeat (2) @(posedge clock);
        check_bit(ovf_irq, 1'b0);
        bus(1'b1, tmr_pkg::IDX_MASK, 8'h00);
    endtask

    task automatic s_cmp();
        bus(1'b1, tmr_pkg::IDX_CMP, 8'h10);
        bus(1'b1, tmr_pkg::IDX_COUNT, 8'h00);
        bus(1'b1, tmr_pkg::IDX_CTRL, ctl(tmr_pkg::COM_OFF, tmr_pkg::WGM_NORMAL, tmr_pkg::CS_DIV1));
        repeat (30) @(posedge clock);
        bus(1'b1, tmr_pkg::IDX_CTRL, 8'h00);
        check_reg(tmr_pkg::IDX_FLAG, 8'h02);
        check_bit(cmp_irq, 1'b0);
        bus(1'b1, tmr_pkg::IDX_MASK, 8'h02);
        repeat (2) @(posedge clock);
        check_bit(cmp_irq, 1'b1);
        @(posedge clock) cmp_irq_ack <= 1'b1;
        @(posedge clock) cmp_irq_ack <= 1'b0;
        repeat (2) @(posedge clock);
        check_bit(cmp_irq, 1'b0);
        check_reg(tmr_pkg::IDX_FLAG, 8'h00);
        bus(1'b1, tmr_pkg::IDX_MASK, 8'h00);
    endtask

    // Run past 255 ticks so a missing clear on match would also overflow
    task automatic s_ctc();
        bus(1'b1, tmr_pkg::IDX_CMP, 8'h05);
        bus(1'b1, tmr_pkg::IDX_COUNT, 8'h00);
        bus(1'b1, tmr_pkg::IDX_CTRL, ctl(tmr_pkg::COM_OFF, tmr_pkg::WGM_CTC, tmr_pkg::CS_DIV1));
        repeat (300) @(posedge clock);
        bus(1'b1, tmr_pkg::IDX_CTRL, 8'h00);
        check_reg(tmr_pkg::IDX_FLAG, 8'h02);
        bus(1'b0, tmr_pkg::IDX_COUNT, 8'h00);
        check_bit(rd <= 8'h05, 1'b1);
        bus(1'b1, tmr_pkg::IDX_FLAG, 8'h03);
    endtask

    // Start and stop writes are 83 cycles apart; prescaler phase is free
    task automatic s_clk(input logic [2:0] cs, input int lo, input int hi);
        bus(1'b1, tmr_pkg::IDX_COUNT, 8'h00);
        bus(1'b1, tmr_pkg::IDX_CTRL, ctl(tmr_pkg::COM_OFF, tmr_pkg::WGM_NORMAL, cs));
        repeat (80) @(posedge clock);
        bus(1'b1, tmr_pkg::IDX_CTRL, 8'h00);
        bus(1'b0, tmr_pkg::IDX_COUNT, 8'h00);
        check_bit(rd >= lo && rd <= hi, 1'b1);
    endtask

    task automatic s_ext(input logic [2:0] cs, input int pulses);
        bus(1'b1, tmr_pkg::IDX_CTRL, ctl(tmr_pkg::COM_OFF, tmr_pkg::WGM_NORMAL, cs));
        bus(1'b1, tmr_pkg::IDX_COUNT, 8'h00);
        for (int i = 0; i < pulses; i++) begin
            @(posedge clock) ext_clock_pin <= 1'b1;
            repeat (4) @(posedge clock);
            ext_clock_pin <= 1'b0;
            repeat (4) @(posedge clock);
        end
        repeat (6) @(posedge clock);
        check_reg(tmr_pkg::IDX_COUNT, 8'(pulses));
    endtask

    task automatic s_wave();
        logic p;
        // Earlier runs passed the compare value; start from clean flags
        bus(1'b1, tmr_pkg::IDX_FLAG, 8'h03);
        bus(1'b1, tmr_pkg::IDX_CTRL, ctl(tmr_pkg::COM_TOGGLE, tmr_pkg::WGM_NORMAL, 3'h0));
        repeat (2) @(posedge clock);
        p = compare_output_pin;
        bus(1'b1, tmr_pkg::IDX_CTRL, 8'h80 | ctl(tmr_pkg::COM_TOGGLE, tmr_pkg::WGM_NORMAL, 3'h0));
        repeat (2) @(posedge clock);
        check_bit(compare_output_pin, ~p);
        check_reg(tmr_pkg::IDX_FLAG, 8'h00);
        bus(1'b1, tmr_pkg::IDX_CMP, 8'h80);
        bus(1'b1, tmr_pkg::IDX_COUNT, 8'h00);
        bus(1'b1, tmr_pkg::IDX_CTRL, ctl(tmr_pkg::COM_CLEAR, tmr_pkg::WGM_PCPWM, tmr_pkg::CS_DIV1));
        // Wait past the first match so the level left by the force is not counted
        repeat (300) @(posedge clock);
        // Two full up-down periods; output high for about half of them
        hi_cnt = 0;
        repeat (1020) begin
            @(posedge clock);
            hi_cnt += int'(compare_output_pin === 1'b1);
        end
        check_bit(hi_cnt >= 480 && hi_cnt <= 540, 1'b1);
        bus(1'b1, tmr_pkg::IDX_CTRL, 8'h00);
        bus(1'b1, tmr_pkg::IDX_CMP, 8'h40);
        bus(1'b1, tmr_pkg::IDX_CTRL, ctl(tmr_pkg::COM_CLEAR, tmr_pkg::WGM_FPWM, tmr_pkg::CS_DIV1));
        repeat (300) @(posedge clock);
        // Four periods of 256; high from wrap up to the match at 0x40
        hi_cnt = 0;
        repeat (1024) begin
            @(posedge clock);
            hi_cnt += int'(compare_output_pin === 1'b1);
        end
        check_bit(hi_cnt >= 248 && hi_cnt <= 272, 1'b1);
        bus(1'b1, tmr_pkg::IDX_CTRL, 8'h00);
    endtask

    initial begin
        err_count = 0;
        n_checks = 0;
        resetn = 1'b0;
        avs_address = 5'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        avs_byteenable = 4'hf;
        cmp_irq_ack = 1'b0;
        ext_clock_pin = 1'b0;
        repeat (6) @(posedge clock);
        resetn <= 1'b1;
        s_regs();
        s_ovf();
        s_cmp();
        s_ctc();
        s_clk(tmr_pkg::CS_DIV1, 82, 84);
        s_clk(tmr_pkg::CS_DIV8, 10, 11);
        s_ext(tmr_pkg::CS_EXTR, 4);
        s_ext(tmr_pkg::CS_EXTF, 3);
        s_wave();
        conclude();
    end
endmodule
`default_nettype wire

// [tmr_pkg.sv]
`default_nettype none
package tmr_pkg;
    // Register word offsets (byte address = 4 * index)
    localparam logic [2:0] IDX_CTRL   = 3'h0;
    localparam logic [2:0] IDX_COUNT  = 3'h1;
    localparam logic [2:0] IDX_CMP    = 3'h2;
    localparam logic [2:0] IDX_FLAG   = 3'h3;
    localparam logic [2:0] IDX_MASK   = 3'h4;
    localparam logic [2:0] IDX_IRQ    = 3'h5;
    // Control register fields
    localparam int CS_LSB    = 0;
    localparam int WGM_LSB   = 3;
    localparam int COM_LSB   = 5;
    localparam int FORCE_BIT = 7;
    // Flag / mask bit positions
    localparam int OVF_BIT   = 0;
    localparam int CMP_BIT   = 1;
    // Counter extremes
    localparam logic [7:0] BOTTOM_VAL = 8'h00;
    localparam logic [7:0] MAX_VAL    = 8'hff;
    // Reset values
    localparam logic [7:0] CTRL_RST  = 8'h00;
    localparam logic [7:0] COUNT_RST = 8'h00;
    localparam logic [7:0] CMP_RST   = 8'h00;
    // Clock select codes
    localparam logic [2:0] CS_STOP   = 3'h0;
    localparam logic [2:0] CS_DIV1   = 3'h1;
    localparam logic [2:0] CS_DIV8   = 3'h2;
    localparam logic [2:0] CS_DIV64  = 3'h3;
    localparam logic [2:0] CS_DIV256 = 3'h4;
    localparam logic [2:0] CS_DIV1K  = 3'h5;
    localparam logic [2:0] CS_EXTF   = 3'h6;
    localparam logic [2:0] CS_EXTR   = 3'h7;
    // Prescaler width (10-bit)
    localparam int PRE_W = 10;
    // Waveform modes
    localparam logic [1:0] WGM_NORMAL = 2'h0;
    localparam logic [1:0] WGM_PCPWM  = 2'h1;
    localparam logic [1:0] WGM_CTC    = 2'h2;
    localparam logic [1:0] WGM_FPWM   = 2'h3;
    // Output action codes
    localparam logic [1:0] COM_OFF    = 2'h0;
    localparam logic [1:0] COM_TOGGLE = 2'h1;
    localparam logic [1:0] COM_CLEAR  = 2'h2;
    localparam logic [1:0] COM_SET    = 2'h3;
endpackage
`default_nettype wire

// [tmr_timer8.sv]
// Chosen here: the Avalon-MM interface to the registers and the placing of the registers.
`default_nettype none
module tmr_timer8 (
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        resetn,
    // Avalon-MM slave
    input  wire logic [4:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    // Interrupt service acknowledge for the compare flag
    input  wire logic        cmp_irq_ack,
    // Pins
    input  wire logic        ext_clock_pin,
    output logic             compare_output_pin,
    // Masked interrupt requests
    output logic             ovf_irq,
    output logic             cmp_irq
);
    typedef enum logic [1:0] {TMR_IDLE, TMR_ACK} tmr_bus_t;

    tmr_bus_t   bus_r;
    logic [7:0] timer_control_reg_r;
    logic [7:0] count_value_r;
    logic [7:0] compare_value_r;
    logic [7:0] cmp_buf_r;
    logic [1:0] timer_flag_reg_r;
    logic [1:0] timer_mask_reg_r;
    logic [9:0] pre_r;
    logic       ext_s1_r;
    logic       ext_s2_r;
    logic       ext_s3_r;
    logic       dir_down_r;
    logic       oc_r;
    logic       blk_r;
    logic [31:0] rdata_r;
    logic       ovf_irq_r;
    logic       cmp_irq_r;
    logic       wait_r;

    function automatic logic pre_tap(input logic [9:0] p, input logic [2:0] cs);
        logic t;
        t = 1'b0;
        case (cs)
            tmr_pkg::CS_DIV1:   t = 1'b1;
            tmr_pkg::CS_DIV8:   t = (p[2:0] == 3'h7);
            tmr_pkg::CS_DIV64:  t = (p[5:0] == 6'h3f);
            tmr_pkg::CS_DIV256: t = (p[7:0] == 8'hff);
            tmr_pkg::CS_DIV1K:  t = (p == 10'h3ff);
            default:            t = 1'b0;
        endcase
        return t;
    endfunction

    // Bus decode
    wire        acc      = (avs_read | avs_write) & (bus_r == TMR_IDLE);
    wire [2:0]  idx      = avs_address[4:2];
    wire        wr       = avs_write & (bus_r == TMR_IDLE) & avs_byteenable[0];
    wire [7:0]  wd       = avs_writedata[7:0];
    wire        wr_ctrl  = wr & (idx == tmr_pkg::IDX_CTRL);
    wire        wr_cnt   = wr & (idx == tmr_pkg::IDX_COUNT);
    wire        wr_cmp   = wr & (idx == tmr_pkg::IDX_CMP);
    wire        wr_flag  = wr & (idx == tmr_pkg::IDX_FLAG);
    wire        wr_mask  = wr & (idx == tmr_pkg::IDX_MASK);

    // Control fields
    wire [2:0]  cs       = timer_control_reg_r[tmr_pkg::CS_LSB +: 3];
    wire [1:0]  wgm      = timer_control_reg_r[tmr_pkg::WGM_LSB +: 2];
    wire [1:0]  com      = timer_control_reg_r[tmr_pkg::COM_LSB +: 2];
    wire        is_pwm   = (wgm == tmr_pkg::WGM_PCPWM) | (wgm == tmr_pkg::WGM_FPWM);
    wire        force_cmp = wr_ctrl & wd[tmr_pkg::FORCE_BIT] & ~is_pwm;

    // Tick generation; the pin is sampled twice, edge taken on the settled pair
    wire        ext_rise = ext_s2_r & ~ext_s3_r;
    wire        ext_fall = ~ext_s2_r & ext_s3_r;
    wire        timer_tick = (cs == tmr_pkg::CS_EXTR) ? ext_rise :
                             (cs == tmr_pkg::CS_EXTF) ? ext_fall :
                             pre_tap(pre_r, cs);

    // Compare and extremes
    wire        at_bottom = (count_value_r == tmr_pkg::BOTTOM_VAL);
    wire        at_max    = (count_value_r == tmr_pkg::MAX_VAL);
    wire        match     = (count_value_r == compare_value_r);
    wire [7:0]  top_val   = (wgm == tmr_pkg::WGM_CTC) ? compare_value_r
                                                      : tmr_pkg::MAX_VAL;
    wire        at_top    = (count_value_r == top_val);
    wire        match_ev  = timer_tick & match & ~blk_r;

    // Next count: write has priority over clear or count
    wire        pc_turn_down = ~dir_down_r & at_top;
    wire        pc_turn_up   = dir_down_r & at_bottom;
    wire        pc_down  = pc_turn_down | (dir_down_r & ~pc_turn_up);
    logic [7:0] count_nxt;
    always_comb begin
        count_nxt = count_value_r;
        if (wr_cnt) begin
            count_nxt = wd;
        end else if (timer_tick) begin
            case (wgm)
                tmr_pkg::WGM_CTC:   count_nxt = at_top ? tmr_pkg::BOTTOM_VAL
                                                       : count_value_r + 8'h01;
                tmr_pkg::WGM_PCPWM: count_nxt = pc_down ? count_value_r - 8'h01
                                                        : count_value_r + 8'h01;
                default:            count_nxt = count_value_r + 8'h01;
            endcase
        end
    end

    // Overflow event per mode
    wire ovf_ev = timer_tick & ((wgm == tmr_pkg::WGM_PCPWM) ? (dir_down_r & at_bottom)
                                                             : at_max);

    // Waveform output
    logic oc_nxt;
    always_comb begin
        oc_nxt = oc_r;
        if (force_cmp | (match_ev & ~is_pwm)) begin
            case (com)
                tmr_pkg::COM_TOGGLE: oc_nxt = ~oc_r;
                tmr_pkg::COM_CLEAR:  oc_nxt = 1'b0;
                tmr_pkg::COM_SET:    oc_nxt = 1'b1;
                default:             oc_nxt = oc_r;
            endcase
        end else if (is_pwm & timer_tick & (com[1])) begin
            if (match) begin
                oc_nxt = (wgm == tmr_pkg::WGM_PCPWM) ? (dir_down_r ^ ~com[0])
                                                     : com[0];
            end else if (wgm == tmr_pkg::WGM_FPWM & at_max) begin
                oc_nxt = ~com[0];
            end
        end
    end

    // Flags: hardware set wins over clear
    logic [1:0] flag_nxt;
    always_comb begin
        flag_nxt = timer_flag_reg_r;
        if (wr_flag) begin
            flag_nxt = flag_nxt & ~wd[1:0];
        end
        if (cmp_irq_ack) begin
            flag_nxt[tmr_pkg::CMP_BIT] = 1'b0;
        end
        if (ovf_ev) begin
            flag_nxt[tmr_pkg::OVF_BIT] = 1'b1;
        end
        if (match_ev) begin
            flag_nxt[tmr_pkg::CMP_BIT] = 1'b1;
        end
    end

    // Double buffered compare: loaded at top (phase PWM) or max (fast PWM)
    wire cmp_load = ~is_pwm |
                    (timer_tick & (wgm == tmr_pkg::WGM_PCPWM) & at_max) |
                    (timer_tick & (wgm == tmr_pkg::WGM_FPWM) & at_max);

    // Read mux
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0000_0000;
        case (idx)
            tmr_pkg::IDX_CTRL:  rd_mux = {24'h0, 1'b0, timer_control_reg_r[6:0]};
            tmr_pkg::IDX_COUNT: rd_mux = {24'h0, count_value_r};
            tmr_pkg::IDX_CMP:   rd_mux = {24'h0, is_pwm ? cmp_buf_r : compare_value_r};
            tmr_pkg::IDX_FLAG:  rd_mux = {30'h0, timer_flag_reg_r};
            tmr_pkg::IDX_MASK:  rd_mux = {30'h0, timer_mask_reg_r};
            tmr_pkg::IDX_IRQ:   rd_mux = {30'h0, cmp_irq_r, ovf_irq_r};
            default:            rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            bus_r <= TMR_IDLE;
            wait_r <= 1'b1;
            rdata_r <= 32'h0000_0000;
        end else begin
            bus_r <= acc ? TMR_ACK : TMR_IDLE;
            rdata_r <= acc ? rd_mux : rdata_r;
            wait_r <= ~acc;
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            timer_control_reg_r <= tmr_pkg::CTRL_RST;
            timer_mask_reg_r <= 2'h0;
            timer_flag_reg_r <= 2'h0;
            cmp_buf_r <= tmr_pkg::CMP_RST;
            compare_value_r <= tmr_pkg::CMP_RST;
        end else begin
            if (wr_ctrl) begin
                timer_control_reg_r <= {1'b0, wd[6:0]};
            end
            if (wr_mask) begin
                timer_mask_reg_r <= wd[1:0];
            end
            timer_flag_reg_r <= flag_nxt;
            cmp_buf_r <= wr_cmp ? wd : cmp_buf_r;
            if (cmp_load) begin
                compare_value_r <= wr_cmp ? wd : cmp_buf_r;
            end
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            count_value_r <= tmr_pkg::COUNT_RST;
            pre_r <= 10'h000;
            ext_s1_r <= 1'b0;
            ext_s2_r <= 1'b0;
            ext_s3_r <= 1'b0;
            dir_down_r <= 1'b0;
            blk_r <= 1'b0;
        end else begin
            count_value_r <= count_nxt;
            pre_r <= (cs == tmr_pkg::CS_STOP) ? pre_r : pre_r + 10'h001;
            ext_s1_r <= ext_clock_pin;
            ext_s2_r <= ext_s1_r;
            ext_s3_r <= ext_s2_r;
            if (wgm != tmr_pkg::WGM_PCPWM) begin
                dir_down_r <= 1'b0;
            end else if (timer_tick & ~wr_cnt) begin
                dir_down_r <= pc_down;
            end
            // A count write hides the next tick's match
            blk_r <= wr_cnt | (blk_r & ~timer_tick);
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            oc_r <= 1'b0;
            compare_output_pin <= 1'b0;
            ovf_irq_r <= 1'b0;
            cmp_irq_r <= 1'b0;
            ovf_irq <= 1'b0;
            cmp_irq <= 1'b0;
        end else begin
            oc_r <= oc_nxt;
            compare_output_pin <= oc_nxt;
            ovf_irq_r <= flag_nxt[0] & timer_mask_reg_r[0];
            cmp_irq_r <= flag_nxt[1] & timer_mask_reg_r[1];
            ovf_irq <= flag_nxt[0] & timer_mask_reg_r[0];
            cmp_irq <= flag_nxt[1] & timer_mask_reg_r[1];
        end
    end

    assign avs_readdata    = rdata_r;
    assign avs_waitrequest = wait_r;

    // Assertions
    AST_STOP_IDLE: assert property (@(posedge clock) disable iff (!resetn)
        (cs == tmr_pkg::CS_STOP && !wr_cnt) |=> $stable(count_value_r))
        else $error("counter moved while stopped");
    AST_WR_PRIO: assert property (@(posedge clock) disable iff (!resetn)
        wr_cnt |=> count_value_r == $past(wd))
        else $error("count write lost");
    AST_CTC_CLR: assert property (@(posedge clock) disable iff (!resetn)
        (wgm == tmr_pkg::WGM_CTC && timer_tick && at_top && !wr_cnt) |=> at_bottom)
        else $error("ctc did not clear");
    AST_CMP_SET: assert property (@(posedge clock) disable iff (!resetn)
        match_ev |=> timer_flag_reg_r[tmr_pkg::CMP_BIT])
        else $error("compare flag not set");
    AST_OVF_SET: assert property (@(posedge clock) disable iff (!resetn)
        (wgm == tmr_pkg::WGM_NORMAL && timer_tick && at_max && !wr_cnt)
        |=> at_bottom && timer_flag_reg_r[tmr_pkg::OVF_BIT])
        else $error("overflow flag not set on wrap");
    AST_ACK_CLR: assert property (@(posedge clock) disable iff (!resetn)
        (cmp_irq_ack && !match_ev) |=> !timer_flag_reg_r[tmr_pkg::CMP_BIT])
        else $error("compare flag not cleared");
    AST_MASK: assert property (@(posedge clock) disable iff (!resetn)
        !timer_mask_reg_r[1] |=> !cmp_irq)
        else $error("masked compare irq raised");
    AST_PC_DOWN: assert property (@(posedge clock) disable iff (!resetn)
        (wgm == tmr_pkg::WGM_PCPWM && timer_tick && at_max && !wr_cnt && $stable(wgm))
        |=> count_value_r == 8'hfe)
        else $error("phase pwm did not turn down");
    AST_BUS_ACK: assert property (@(posedge clock) disable iff (!resetn)
        acc |=> !avs_waitrequest ##1 avs_waitrequest)
        else $error("bus answer not one cycle");
    AST_OVF_MASK: assert property (@(posedge clock) disable iff (!resetn)
        !timer_mask_reg_r[tmr_pkg::OVF_BIT] |=> !ovf_irq)
        else $error("masked overflow irq raised");
    AST_OVF_SEEN: assert property (@(posedge clock) disable iff (!resetn)
        ovf_irq |-> timer_flag_reg_r[tmr_pkg::OVF_BIT])
        else $error("overflow request without flag");
    AST_CMP_SEEN: assert property (@(posedge clock) disable iff (!resetn)
        cmp_irq |-> timer_flag_reg_r[tmr_pkg::CMP_BIT])
        else $error("compare request without flag");
    AST_FLAG_W1C: assert property (@(posedge clock) disable iff (!resetn)
        (wr_flag && wd[tmr_pkg::CMP_BIT] && !match_ev) |=> !timer_flag_reg_r[tmr_pkg::CMP_BIT])
        else $error("compare flag not cleared by write");
    AST_EXT_EDGE: assert property (@(posedge clock) disable iff (!resetn)
        (cs == tmr_pkg::CS_EXTR && timer_tick)
        |-> ($past(ext_clock_pin, 2) && !$past(ext_clock_pin, 3)))
        else $error("external tick without a settled rising edge");
    AST_STOP_TICK: assert property (@(posedge clock) disable iff (!resetn)
        (cs == tmr_pkg::CS_STOP) |-> !timer_tick)
        else $error("tick while stopped");
    AST_STOP_PRE: assert property (@(posedge clock) disable iff (!resetn)
        (cs == tmr_pkg::CS_STOP) |=> $stable(pre_r))
        else $error("prescaler ran while stopped");
    AST_PC_UP: assert property (@(posedge clock) disable iff (!resetn)
        (wgm == tmr_pkg::WGM_PCPWM && timer_tick && at_bottom && dir_down_r && !wr_cnt)
        |=> count_value_r == 8'h01)
        else $error("phase pwm did not turn up");
    AST_FPWM_SET: assert property (@(posedge clock) disable iff (!resetn)
        (wgm == tmr_pkg::WGM_FPWM && com == tmr_pkg::COM_CLEAR && timer_tick && at_max
         && !match) |=> compare_output_pin)
        else $error("fast pwm output not set at wrap");
    AST_FORCE_TGL: assert property (@(posedge clock) disable iff (!resetn)
        (force_cmp && com == tmr_pkg::COM_TOGGLE)
        |=> compare_output_pin != $past(compare_output_pin))
        else $error("forced compare did not toggle output");
    AST_CMP_HOLD: assert property (@(posedge clock) disable iff (!resetn)
        (is_pwm && !(timer_tick && at_max)) |=> $stable(compare_value_r))
        else $error("compare value changed mid period");
endmodule
`default_nettype wire
